/* hdl/pcm_link_if.sv */
// word link between the playback engine and the serial audio port end
// assumes both ends run on the same clock; the bench owns the instance
`timescale 1ns/1ps
interface pcm_link_if;
   logic [31:0] word;
   logic        word_valid;
   logic        word_ready;
   logic        dma_req;
   logic        clock_request;

   modport dma_end  (output word, word_valid, clock_request,
                     input  word_ready, dma_req);
   modport port_end (input  word, word_valid, clock_request,
                     output word_ready, dma_req);
endinterface

/* hdl/pcm_playback_dma.sv */
// playback engine: word reads from on-chip sram, words out over the link
// assumes a classic wishbone master, an sram that answers with a valid
// strobe, and the serial port end on the same clock
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Operation
// R01 - reads only on-chip sram, 128 KB
// R02 - memory to port direction only
// R03 - start addresses word aligned
// R04 - length 1 to 8000h words
// R05 - reserved transfer starts when current finishes
// R06 - path exclusive with general dma controller
// R07 - software disables sram clock gating first
// R08 - software may re-enable gating after start
// R09 - keeps transferring in power saving mode
// R10 - register, memory and port clocks served
// R11 - clock request while any interface busy
// R12 - power manager holds clocks while requested
// R13 - start or reserve; third command flags error
// R14 - state code 00, 01, 10
// R15 - cancel drops reservation while transferring
// R16 - forced stop resets whole engine
// R17 - cross-domain commands neither lost nor doubled
module pcm_playback_dma
   import pcm_playback_dma_pkg::*;
(
   // clock and reset
   input  wire logic             I_CLK,
   input  wire logic             I_RESET_N,
   // wishbone slave
   input  wire logic             I_WB_CYC,
   input  wire logic             I_WB_STB,
   input  wire logic             I_WB_WE,
   input  wire logic [ADR_W-1:0] I_WB_ADR,
   input  wire logic [DAT_W-1:0] I_WB_DAT,
   input  wire logic [SEL_W-1:0] I_WB_SEL,
   output logic      [DAT_W-1:0] O_WB_DAT,
   output logic                  O_WB_ACK,
   // sram read port
   input  wire logic [DAT_W-1:0] I_SRAM_DATA,
   input  wire logic             I_SRAM_VALID,
   output logic                  O_SRAM_RD,
   output logic    [SRAM_AW-1:0] O_SRAM_ADDR,
   output logic                  O_SRAM_GATE_EN,
   // system side
   output logic                  O_PATH_SEL,
   output logic                  O_GDMA_REQ,
   output logic                  O_CLOCK_REQUEST,
   output logic                  O_IRQ,
   // link toward the serial port
   pcm_link_if.dma_end           LINK
);
   import pcm_playback_dma_pkg::*;

   run_state_e       state_q;
   fetch_state_e     fetch_q;
   logic             ack_q;
   logic [DAT_W-1:0] rd_data_d;
   logic [DAT_W-1:0] rd_data_q;
   logic             path_sel_q;
   logic             gate_en_q;
   logic [31:0]      rsv_addr_q;
   logic [LEN_W-1:0] rsv_len_q;
   logic [31:0]      run_addr_q;
   logic [LEN_W-1:0] run_len_q;
   logic [31:0]      ptr_q;
   logic [LEN_W-1:0] remain_q;
   logic [DAT_W-1:0] word_q;
   logic [INT_W-1:0] int_raw_q;
   logic [INT_W-1:0] int_en_q;
   logic             operation_error_flag_q;
   logic [31:0]      scratch_q;

   logic wr;
   logic start_cmd;
   logic cancel_cmd;
   logic stop_cmd;
   logic len_ok;
   logic word_sent;
   logic done;
   logic load;
   logic err_evt;

   // byte-lane merge for writable words
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction

   function automatic logic wr_at(input logic [7:0] ofs);
      return wr && (I_WB_ADR == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus decode; one clock serves register, memory and port sides, so
   // each command is a single-cycle strobe with no crossing to lose it
   assign wr         = I_WB_CYC & I_WB_STB & I_WB_WE & ~ack_q; // R10 R17
   // always_comb, so the decode also follows wr and the address read inside wr_at
   always_comb begin
      start_cmd  = wr_at(OFS_START)  & I_WB_SEL[0] & I_WB_DAT[CMD_BIT];
      cancel_cmd = wr_at(OFS_CANCEL) & I_WB_SEL[0] & I_WB_DAT[CMD_BIT];
      stop_cmd   = wr_at(OFS_STOP)   & I_WB_SEL[0] & I_WB_DAT[CMD_BIT];
   end
   // zero or oversize length is never loaded, so no words move; a start while transferring still reserves
   assign len_ok     = (rsv_len_q != '0) && (rsv_len_q <= MAX_LEN_WORDS); // R04

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= I_WB_CYC & I_WB_STB & ~ack_q;
      end
   end

   always_comb begin
      rd_data_d = RST_WORD;
      case (I_WB_ADR)
         OFS_PATH_SEL:   rd_data_d[0]         = path_sel_q;
         OFS_STATE:      rd_data_d[1:0]       = state_q; // R14
         OFS_RSV_ADDR:   rd_data_d            = rsv_addr_q;
         OFS_RSV_LEN:    rd_data_d[LEN_W-1:0] = rsv_len_q;
         OFS_RUN_ADDR:   rd_data_d            = run_addr_q;
         OFS_RUN_LEN:    rd_data_d[LEN_W-1:0] = run_len_q;
         OFS_INT_MASKED: rd_data_d[INT_W-1:0] = int_raw_q & int_en_q;
         OFS_INT_RAW:    rd_data_d[INT_W-1:0] = int_raw_q;
         OFS_INT_EN:     rd_data_d[INT_W-1:0] = int_en_q;
         OFS_RUN_PTR:    rd_data_d            = ptr_q;
         OFS_ERROR:      rd_data_d[0]         = operation_error_flag_q;
         OFS_SCRATCH:    rd_data_d            = scratch_q;
         OFS_SRAM_GATE:  rd_data_d[0]         = gate_en_q;
         default:        rd_data_d            = RST_WORD;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rd_data_q <= RST_WORD;
      end else if (I_WB_CYC && I_WB_STB && !ack_q) begin
         rd_data_q <= rd_data_d;
      end
   end

   assign O_WB_ACK = ack_q;
   assign O_WB_DAT = rd_data_q;

   ////////////////////////////////////////////////////////////////////////
   // software-owned settings; forced stop clears them all
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         path_sel_q <= 1'b0;
         gate_en_q  <= 1'b0;
         rsv_addr_q <= RST_WORD;
         rsv_len_q  <= '0;
         scratch_q  <= RST_WORD;
         int_en_q   <= '0;
      end else if (stop_cmd) begin
         path_sel_q <= 1'b0; // R16
         gate_en_q  <= 1'b0;
         rsv_addr_q <= RST_WORD;
         rsv_len_q  <= '0;
         scratch_q  <= RST_WORD;
         int_en_q   <= '0;
      end else begin
         if (wr_at(OFS_PATH_SEL) && I_WB_SEL[0]) path_sel_q <= I_WB_DAT[0];
         // gating stays under software control, also while playing
         if (wr_at(OFS_SRAM_GATE) && I_WB_SEL[0]) gate_en_q <= I_WB_DAT[0];
         if (wr_at(OFS_RSV_ADDR)) begin
            rsv_addr_q <= merge(rsv_addr_q, I_WB_DAT, I_WB_SEL) & ADDR_MASK; // R03
         end
         if (wr_at(OFS_RSV_LEN)) begin
            rsv_len_q <= LEN_W'(merge({16'h0000, rsv_len_q}, I_WB_DAT, I_WB_SEL));
         end
         if (wr_at(OFS_SCRATCH)) scratch_q <= merge(scratch_q, I_WB_DAT, I_WB_SEL);
         if (wr_at(OFS_INT_EN)) begin
            int_en_q <= int_en_q | I_WB_DAT[INT_W-1:0];
         end else if (wr_at(OFS_INT_EN_CLR)) begin
            int_en_q <= int_en_q & ~I_WB_DAT[INT_W-1:0];
         end
      end
   end

   assign O_PATH_SEL     = path_sel_q;
   assign O_SRAM_GATE_EN = gate_en_q;
   // port request goes to whichever controller owns the path
   assign O_GDMA_REQ     = LINK.dma_req & ~path_sel_q; // R06

   ////////////////////////////////////////////////////////////////////////
   // run state: stopped, transferring, reserved
   assign word_sent = (fetch_q == FE_SEND) && LINK.word_ready;
   assign done      = word_sent && (remain_q == 16'h0001);
   assign err_evt   = start_cmd && (state_q == ST_RESERVED) && !done;
   assign load      = ((state_q == ST_STOPPED) && start_cmd && len_ok && path_sel_q)
                   || ((state_q == ST_XFER) && done && start_cmd && len_ok)
                   || ((state_q == ST_RESERVED) && done && !cancel_cmd && len_ok);

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state_q <= ST_STOPPED;
      end else if (stop_cmd) begin
         state_q <= ST_STOPPED; // R16
      end else begin
         case (state_q)
            ST_STOPPED: begin
               if (load) state_q <= ST_XFER; // R13
            end
            ST_XFER: begin
               if (load) state_q <= ST_XFER;
               else if (done) state_q <= ST_STOPPED;
               else if (start_cmd) state_q <= ST_RESERVED; // R13
            end
            ST_RESERVED: begin
               if (load) state_q <= ST_XFER; // R05
               else if (done) state_q <= ST_STOPPED;
               else if (cancel_cmd) state_q <= ST_XFER; // R15
            end
            default: state_q <= ST_STOPPED;
         endcase
      end
   end

   // run copies are taken at start and at automatic restart
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         run_addr_q <= RST_WORD;
         run_len_q  <= '0;
         ptr_q      <= RST_WORD;
         remain_q   <= '0;
      end else if (stop_cmd) begin
         run_addr_q <= RST_WORD;
         run_len_q  <= '0;
         ptr_q      <= RST_WORD;
         remain_q   <= '0;
      end else if (load) begin
         run_addr_q <= rsv_addr_q;
         run_len_q  <= rsv_len_q;
         ptr_q      <= rsv_addr_q;
         remain_q   <= rsv_len_q; // R04
      end else if (word_sent) begin
         ptr_q    <= ptr_q + 32'h0000_0004;
         remain_q <= remain_q - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fetch: one word read, then offered on the link; runs on the bus clock
   // alone, so power saving on the cpu side does not stall playback
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         fetch_q <= FE_IDLE;
      end else if (stop_cmd) begin
         fetch_q <= FE_IDLE;
      end else begin
         case (fetch_q)
            FE_IDLE: begin
               if (state_q != ST_STOPPED && remain_q != '0 && path_sel_q
                   && LINK.dma_req) begin
                  fetch_q <= FE_READ; // R09
               end
            end
            FE_READ: begin
               if (I_SRAM_VALID) fetch_q <= FE_SEND;
            end
            FE_SEND: begin
               if (LINK.word_ready) fetch_q <= FE_IDLE;
            end
            default: fetch_q <= FE_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         word_q <= RST_WORD;
      end else if (fetch_q == FE_READ && I_SRAM_VALID) begin
         word_q <= I_SRAM_DATA;
      end
   end

   // address wraps inside the sram window, word aligned
   assign O_SRAM_RD       = (fetch_q == FE_READ);
   assign O_SRAM_ADDR     = ptr_q[SRAM_AW-1:0] & ADDR_MASK[SRAM_AW-1:0]; // R01 R03
   assign LINK.word       = word_q; // R02
   assign LINK.word_valid = (fetch_q == FE_SEND);
   assign LINK.clock_request = (state_q != ST_STOPPED) || (fetch_q != FE_IDLE)
                            || I_WB_CYC || ack_q; // R11

   ////////////////////////////////////////////////////////////////////////
   // events: sticky, set wins over a clearing write
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         int_raw_q <= '0;
         operation_error_flag_q  <= 1'b0;
      end else if (stop_cmd) begin
         int_raw_q <= '0;
         operation_error_flag_q  <= 1'b0;
      end else begin
         for (int b = 0; b < INT_W; b++) begin
            if ((b == INT_DONE_BIT && done) || (b == INT_ERR_BIT && err_evt)) begin
               int_raw_q[b] <= 1'b1;
            end else if (wr_at(OFS_INT_CLR) && I_WB_DAT[b]) begin
               int_raw_q[b] <= 1'b0;
            end
         end
         if (err_evt) begin
            operation_error_flag_q <= 1'b1; // R13
         end else if (wr_at(OFS_ERROR) && I_WB_SEL[0]) begin
            operation_error_flag_q <= I_WB_DAT[0];
         end
      end
   end

   assign O_CLOCK_REQUEST = LINK.clock_request;
   assign O_IRQ           = |(int_raw_q & int_en_q);

endmodule

/* hdl/pcm_playback_dma_pkg.sv */
// constants shared by the playback engine, its bench and the serial port end
// assumes byte addressing on the register bus, one 32-bit word per register
package pcm_playback_dma_pkg;

   // register bus geometry
   localparam int         ADR_W          = 8;
   localparam int         DAT_W          = 32;
   localparam int         SEL_W          = 4;

   // register byte offsets
   localparam logic [7:0] OFS_PATH_SEL   = 8'h00;
   localparam logic [7:0] OFS_START      = 8'h04;
   localparam logic [7:0] OFS_STATE      = 8'h08;
   localparam logic [7:0] OFS_CANCEL     = 8'h0C;
   localparam logic [7:0] OFS_STOP       = 8'h10;
   localparam logic [7:0] OFS_RSV_ADDR   = 8'h20;
   localparam logic [7:0] OFS_RSV_LEN    = 8'h24;
   localparam logic [7:0] OFS_RUN_ADDR   = 8'h28;
   localparam logic [7:0] OFS_RUN_LEN    = 8'h2C;
   localparam logic [7:0] OFS_INT_MASKED = 8'h30;
   localparam logic [7:0] OFS_INT_RAW    = 8'h34;
   localparam logic [7:0] OFS_INT_EN     = 8'h38;
   localparam logic [7:0] OFS_INT_EN_CLR = 8'h3C;
   localparam logic [7:0] OFS_INT_CLR    = 8'h40;
   localparam logic [7:0] OFS_RUN_PTR    = 8'h50;
   localparam logic [7:0] OFS_ERROR      = 8'h54;
   localparam logic [7:0] OFS_SCRATCH    = 8'h58;
   localparam logic [7:0] OFS_SRAM_GATE  = 8'h60;

   // field positions and reset values
   localparam int          CMD_BIT       = 0;
   localparam int          INT_DONE_BIT  = 0;
   localparam int          INT_ERR_BIT   = 1;
   localparam int          INT_W         = 2;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
   localparam logic [31:0] ADDR_MASK     = 32'hFFFF_FFFC;

   // source memory and transfer length
   localparam int          SRAM_AW       = 17;
   localparam logic [16:0] WORD_STEP     = 17'h0_0004;
   localparam int          LEN_W         = 16;
   localparam logic [15:0] MAX_LEN_WORDS = 16'h8000;

   typedef enum logic [1:0] {
      ST_STOPPED  = 2'b00,
      ST_XFER     = 2'b01,
      ST_RESERVED = 2'b10
   } run_state_e;

   typedef enum logic [1:0] {
      FE_IDLE = 2'b00,
      FE_READ = 2'b01,
      FE_SEND = 2'b10
   } fetch_state_e;

endpackage

/* hdl/pcm_serial_port_end.sv */
// serial audio port end of the link: one-word holding register
// assumes the user side takes samples with a take strobe on I_CLK
`timescale 1ns/1ps
module pcm_serial_port_end
   import pcm_playback_dma_pkg::*;
(
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RESET_N,
   // link toward the engine
   pcm_link_if.port_end     LINK,
   // user side
   input  wire logic        I_ENABLE,
   input  wire logic        I_SAMPLE_TAKE,
   output logic [DAT_W-1:0] O_SAMPLE,
   output logic             O_SAMPLE_VALID,
   output logic             O_CLOCK_HOLD
);
   import pcm_playback_dma_pkg::*;

   logic             full_q;
   logic [DAT_W-1:0] sample_q;
   logic             hold_q;

   // level request, as the engine samples levels and not edges
   assign LINK.dma_req    = I_ENABLE & ~full_q;
   assign LINK.word_ready = ~full_q;
   assign O_SAMPLE        = sample_q;
   assign O_SAMPLE_VALID  = full_q;
   assign O_CLOCK_HOLD    = hold_q;

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         full_q <= 1'b0;
      end else if (LINK.word_valid && !full_q) begin
         full_q <= 1'b1;
      end else if (I_SAMPLE_TAKE) begin
         full_q <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sample_q <= RST_WORD;
      end else if (LINK.word_valid && !full_q) begin
         sample_q <= LINK.word;
      end
   end

   // clocks stay granted while the engine asks
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= LINK.clock_request; // R12
      end
   end

endmodule

/* sim/pcm_playback_dma_assertions.sv */
// link-side checker for the playback engine facing the serial port end
// assumes the bench holds the port enable high and takes every sample promptly
`timescale 1ns/1ps
module pcm_playback_dma_assertions (
   // clock and reset
   input wire logic        I_CLK,
   input wire logic        I_RESET_N,
   // link signals
   input wire logic [31:0] word,
   input wire logic        word_valid,
   input wire logic        word_ready,
   input wire logic        dma_req,
   input wire logic        clock_request
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   ////////////////////////////////////////////////////////////////////////////
   a_clock_request_line_on_word: assert property (word_valid |-> clock_request)
      else $error("clock request low while a word is offered");
   a_word_spacing: assert property (word_valid && word_ready |=> (!word_valid) [*2])
      else $error("words closer than three cycles");
   a_full_after_take: assert property (word_valid && word_ready |=> !word_ready && !dma_req)
      else $error("port end still open after taking a word");
   a_req_needs_room: assert property (dma_req |-> word_ready)
      else $error("port requests while its holder is full");
   a_word_after_req: assert property ($rose(word_valid) |-> $past(dma_req) && $past(dma_req, 2))
      else $error("word offered without a standing request");
   a_room_returns: assert property (!word_ready |-> ##[1:4] word_ready)
      else $error("port end stays full");
   // with the enable held high the request only drops when the port end accepts a word
   a_req_drop_cause: assert property ($fell(dma_req) |-> $past(word_valid) && $past(word_ready))
      else $error("request dropped without a word moving");
   a_word_meets_room: assert property ($rose(word_valid) |-> word_ready)
      else $error("word offered into a full port end");
   ////////////////////////////////////////////////////////////////////////////
   c_word_moves: cover property (word_valid && word_ready && word != 32'h0000_0000);
   c_back_to_back: cover property (word_valid && word_ready ##[3:12] word_valid && word_ready);
   c_port_full: cover property (!word_ready ##1 word_ready);
endmodule

/* sim/pcm_playback_dma_with_reservation_test.sv */
// bench: engine and port end joined by the link, wishbone master, sram model
// assumes one 100 MHz clock for everything and the package register map
`timescale 1ns/1ps
module pcm_playback_dma_with_reservation_test;
   import pcm_playback_dma_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] rdat;
   logic        ack;
   logic [31:0] sram_data = 32'h0;
   logic        sram_valid = 1'b0;
   logic [1:0]  dly = 2'h0;
   logic        sram_rd, gate_en, path_sel, gdma_req, clk_req, irq;
   logic [16:0] sram_addr;
   logic        take = 1'b0;
   logic [31:0] sample;
   logic        sample_valid, clock_hold;
   logic [31:0] got[$];
   logic [31:0] exp_q[$];
   logic [31:0] q;
   int          errors = 0;
   int          compares = 0;
   pcm_link_if link();
   pcm_playback_dma i_pcm_playback_dma (.I_CLK(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SRAM_DATA(sram_data), .I_SRAM_VALID(sram_valid),
      .O_SRAM_RD(sram_rd), .O_SRAM_ADDR(sram_addr), .O_SRAM_GATE_EN(gate_en),
      .O_PATH_SEL(path_sel), .O_GDMA_REQ(gdma_req), .O_CLOCK_REQUEST(clk_req),
      .O_IRQ(irq), .LINK(link));
   pcm_serial_port_end i_pcm_serial_port_end (.I_CLK(clk), .I_RESET_N(rst_n), .LINK(link),
      .I_ENABLE(1'b1), .I_SAMPLE_TAKE(take), .O_SAMPLE(sample),
      .O_SAMPLE_VALID(sample_valid), .O_CLOCK_HOLD(clock_hold));
   pcm_playback_dma_assertions i_pcm_playback_dma_assertions (.I_CLK(clk), .I_RESET_N(rst_n),
      .word(link.word), .word_valid(link.word_valid), .word_ready(link.word_ready),
      .dma_req(link.dma_req), .clock_request(link.clock_request));
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   // sram: odd words answer slowly, even words at once; data scrambled when idle
   always @(posedge clk) begin
      if (sram_rd && !sram_valid && dly == {sram_addr[2], sram_addr[2]}) begin
         sram_valid <= 1'b1;
         sram_data <= 32'hC0DE_0000 ^ {15'h0, sram_addr};
         dly <= 2'h0;
      end else begin
         sram_valid <= 1'b0;
         sram_data <= ~sram_data;
         dly <= (sram_rd && !sram_valid) ? dly + 2'h1 : 2'h0;
      end
   end
   always @(posedge clk) begin
      take <= sample_valid && !take;
      if (sample_valid && !take) begin
         got.push_back(sample);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            break;
         end
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n == 50) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] want);
      wb(1'b0, a, 32'h0);
      check(q, want);
   endtask
   task automatic start(input logic [31:0] a, input logic [31:0] len);
      wr(OFS_RSV_ADDR, a);
      wr(OFS_RSV_LEN, len);
      wr(OFS_START, 32'h1);
   endtask
   task automatic wait_stop();
      for (int i = 0; i < 400; i++) begin
         wb(1'b0, OFS_STATE, 32'h0);
         if (q[1:0] === 2'b00) begin
            return;
         end
      end
      errors++;
      print_verdict();
   endtask
   task automatic expect_words(input logic [16:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(32'hC0DE_0000 ^ {15'h0, a});
         a = a + WORD_STEP;
      end
   endtask
   task automatic cmp_words();
      check(32'(got.size()), 32'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < got.size()) begin
            check(got[i], exp_q[i]);
         end
      end
      got.delete();
      exp_q.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rchk(OFS_STATE, 32'h0);
      rchk(8'h14, 32'h0);
      check({31'h0, gdma_req}, 32'h1);
      start(32'h100, 32'h4);
      rchk(OFS_STATE, 32'h0);
      wr(OFS_SRAM_GATE, 32'h0);
      wr(OFS_PATH_SEL, 32'h1);
      check({31'h0, gdma_req}, 32'h0);
      check({31'h0, path_sel}, 32'h1);
      wr(OFS_RSV_ADDR, 32'h102);
      rchk(OFS_RSV_ADDR, 32'h100);
      // zero and one past the longest length are both refused
      start(32'h100, 32'h0);
      rchk(OFS_STATE, 32'h0);
      start(32'h100, 32'h8001);
      rchk(OFS_STATE, 32'h0);
      wr(OFS_INT_EN, 32'h3);
      start(32'h100, 32'h8);
      rchk(OFS_STATE, 32'h1);
      check({31'h0, clk_req}, 32'h1);
      check({31'h0, clock_hold}, 32'h1);
      wr(OFS_SRAM_GATE, 32'h1);
      check({31'h0, gate_en}, 32'h1);
      start(32'h200, 32'h2);
      rchk(OFS_STATE, 32'h2);
      wr(OFS_START, 32'h1);
      rchk(OFS_ERROR, 32'h1);
      wb(1'b0, OFS_INT_RAW, 32'h0);
      check(q & 32'h2, 32'h2);
      check({31'h0, irq}, 32'h1);
      wait_stop();
      expect_words(17'h100, 8);
      expect_words(17'h200, 2);
      cmp_words();
      rchk(OFS_INT_RAW, 32'h3);
      wr(OFS_INT_CLR, 32'h3);
      rchk(OFS_INT_RAW, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(OFS_INT_EN_CLR, 32'h3);
      rchk(OFS_INT_EN, 32'h0);
      wr(OFS_ERROR, 32'h0);
      wr(OFS_CANCEL, 32'h1);
      rchk(OFS_STATE, 32'h0);
      start(32'h300, 32'h6);
      start(32'h400, 32'h4);
      wr(OFS_CANCEL, 32'h1);
      rchk(OFS_STATE, 32'h1);
      wait_stop();
      expect_words(17'h300, 6);
      cmp_words();
      check({31'h0, irq}, 32'h0);
      wr(OFS_SCRATCH, 32'hA5A5_5A5A);
      rchk(OFS_SCRATCH, 32'hA5A5_5A5A);
      start(32'h500, 32'h8);
      wr(OFS_STOP, 32'h1);
      rchk(OFS_STATE, 32'h0);
      rchk(OFS_PATH_SEL, 32'h0);
      rchk(OFS_RSV_LEN, 32'h0);
      rchk(OFS_SCRATCH, 32'h0);
      rchk(OFS_INT_RAW, 32'h0);
      repeat (10) @(posedge clk);
      check({31'h0, clk_req}, 32'h0);
      check({31'h0, clock_hold}, 32'h0);
      got.delete();
      print_verdict();
   end
endmodule
